// ===== rtl/mrar_regs.sv
// monitor result, output code, alert status and configuration registers
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module mrar_regs
   import mrar_pkg::*;
#(
   parameter int unsigned REFRESH_CYC = REFRESH_CYCLES
)
(
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [DATA_W-1:0] reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [DATA_W-1:0] reg_rdata_o,
   input  wire logic              sys_clk_i,
   input  wire logic              rstn_i,
   input  wire logic [TEMP_W-1:0] remote_diode_one_temp_i,
   input  wire logic [TEMP_W-1:0] remote_diode_two_temp_i,
   input  wire logic [TEMP_W-1:0] ondie_thermal_sensor_temp_i,
   input  wire logic              remote_diode_one_open_i,
   input  wire logic              remote_diode_two_open_i,
   input  wire logic [STAT_W-1:0] voltage_evt_i,
   input  wire logic [STAT_W-1:0] current_evt_i,
   input  wire logic [STAT_W-1:0] thermal_evt_i,
   output logic                   refresh_o,
   output logic      [CODE_W-1:0] analog_output_a_o,
   output logic      [CODE_W-1:0] analog_output_b_o,
   output logic      [CODE_W-1:0] analog_output_c_o,
   output logic      [CODE_W-1:0] analog_output_d_o,
   output logic      [STAT_W-1:0] autocycle_select_o,
   output logic      [DATA_W-1:0] config_o
);

   ////////////////////////////////////////////////////////////////////////
   // elaboration checks

   localparam int CNT_W  = (REFRESH_CYC > 2) ? $clog2(REFRESH_CYC) : 1;
   localparam int CODE_N = 4;

   // the packing below hard-wires these layouts, so refuse any other
   generate
      if (REFRESH_CYC < 2) begin : g_bad_refresh
         $error("refresh period must be at least two cycles");
      end
      if (RES_ALERT_BIT != DATA_W - 1) begin : g_bad_alert_bit
         $error("alert marker must be the top bit of a result");
      end
      if (RES_CHAN_LSB + CHAN_W != RES_ALERT_BIT) begin : g_bad_chan
         $error("channel code must sit just below the alert marker");
      end
      if (RES_OPEN_BIT + 1 != RES_CHAN_LSB) begin : g_bad_open_bit
         $error("open diode bit must sit just below the channel code");
      end
      if (TEMP_W != RES_OPEN_BIT) begin : g_bad_temp
         $error("temperature must fill the bits below the open flag");
      end
      if (CODE_W > DATA_W) begin : g_bad_code
         $error("output code cannot be wider than a data word");
      end
      if (BYTE_W + STAT_W != DATA_W) begin : g_bad_stat
         $error("status and sequence words must fill the low byte");
      end
      if (int'(ADDR_CODE_D - ADDR_CODE_A) != CODE_N - 1) begin : g_bad_codes
         $error("output code addresses must cover every code register");
      end
      if (STAT_THERM_IDX >= STAT_N) begin : g_bad_therm
         $error("thermal status index outside the status bank");
      end
      if (CHAN_REMOTE_ONE == CHAN_REMOTE_TWO) begin : g_bad_chan_codes
         $error("remote diodes need distinct channel codes");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic [CNT_W-1:0]  refresh_cnt_q;
   logic              refresh_tick;
   logic              refresh_q;

   mrar_word_t        remote_one_q;
   mrar_word_t        remote_two_q;
   mrar_word_t        ondie_q;

   logic [CODE_W-1:0] code_q [CODE_N];
   mrar_stat_t        seq_q;
   mrar_word_t        cfg_q;
   mrar_word_t        rdata_q;

   logic              wr_code;
   logic              wr_stat;
   logic              wr_seq;
   logic              wr_cfg;
   logic              clr_all;
   logic [1:0]        code_idx;
   logic [1:0]        stat_idx;

   mrar_stat_t        stat_evt [STAT_N];
   mrar_stat_t        stat_clr [STAT_N];
   mrar_stat_t        stat_q   [STAT_N];
   mrar_stat_t        therm_now;
   logic              mark_one;
   logic              mark_two;
   logic              mark_ondie;

   localparam mrar_stat_t STAT_MASKS [STAT_N] = '{
      STAT_VOLT_MASK, STAT_CURR_MASK, STAT_THERM_MASK};

   ////////////////////////////////////////////////////////////////////////
   // shared decoding

   // both diodes take one packing, so their layouts cannot drift apart
   function automatic mrar_word_t pack_remote(
      input logic              mark,
      input logic [CHAN_W-1:0] chan,
      input logic              open_flag,
      input logic [TEMP_W-1:0] temp
   );
      return {mark, chan, open_flag, temp};
   endfunction

   // flagged by its own limits, by overtemperature or by an open input
   function automatic logic diode_mark(
      input mrar_stat_t therm,
      input mrar_stat_t group,
      input logic       open_flag
   );
      return |(therm & group) || therm[THERM_OVER_BIT] || open_flag;
   endfunction

   // status and sequence registers sit in the low byte of the word
   function automatic mrar_word_t low_byte(input mrar_stat_t value);
      return {BYTE_W'(0), value};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // write decode

   // a write to a shared address never touches the result there
   always_comb begin
      wr_code  = reg_wr_i && mrar_is_code_addr(reg_addr_i);
      wr_stat  = reg_wr_i && mrar_is_stat_addr(reg_addr_i);
      wr_seq   = reg_wr_i && (reg_addr_i == ADDR_SEQUENCE);
      wr_cfg   = reg_wr_i && (reg_addr_i == ADDR_CONFIG);
      code_idx = 2'(reg_addr_i - ADDR_CODE_A);
      stat_idx = 2'(reg_addr_i - ADDR_STAT_FIRST);
      clr_all  = wr_cfg && reg_wdata_i[CFG_CLR_BIT_A]
                        && reg_wdata_i[CFG_CLR_BIT_B];
   end

   ////////////////////////////////////////////////////////////////////////
   // conversion refresh timer

   // free running, so results age no more than one period whatever
   // the host does on the bus
   assign refresh_tick = (refresh_cnt_q == CNT_W'(REFRESH_CYC - 1));

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         refresh_cnt_q <= '0;
      end else if (refresh_tick) begin
         refresh_cnt_q <= '0;
      end else begin
         refresh_cnt_q <= refresh_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         refresh_q <= 1'b0;
      end else begin
         refresh_q <= refresh_tick;
      end
   end

   assign refresh_o = refresh_q;

   ////////////////////////////////////////////////////////////////////////
   // alert status registers

   generate
      for (genvar i = 0; i < STAT_N; i++) begin : g_stat
         mrar_stat_if u_if ();

         // reserved bits are masked inside, so they stay zero
         assign u_if.mask = STAT_MASKS[i];
         assign u_if.evt  = stat_evt[i];
         assign u_if.clr  = stat_clr[i];
         assign stat_q[i] = u_if.q;

         mrar_alert_stat u_stat (
            .sys_clk_i (sys_clk_i),
            .rstn_i    (rstn_i),
            .port      (u_if.stat)
         );
      end
   endgenerate

   // events land straight in the bits they name
   always_comb begin
      stat_evt[0] = voltage_evt_i;
      stat_evt[1] = current_evt_i;
      stat_evt[2] = thermal_evt_i;
   end

   // write-one-to-clear; all ones clears the whole register
   always_comb begin
      for (int i = 0; i < STAT_N; i++) begin
         stat_clr[i] = '0;
         if (clr_all) begin
            stat_clr[i] = STAT_ALL_ONES;
         end else if (wr_stat && (stat_idx == 2'(i))) begin
            stat_clr[i] = reg_wdata_i[STAT_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // alert markers for the result words

   // include this cycle's events so a marker is not one refresh late
   always_comb begin
      therm_now  = stat_q[STAT_THERM_IDX] | thermal_evt_i;
      mark_one   = diode_mark(therm_now, THERM_ONE_MASK,
                              remote_diode_one_open_i);
      mark_two   = diode_mark(therm_now, THERM_TWO_MASK,
                              remote_diode_two_open_i);
      mark_ondie = |stat_q[0] || |stat_q[1] || |therm_now
                   || |voltage_evt_i || |current_evt_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // temperature result registers

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         remote_one_q <= '0;
         remote_two_q <= '0;
         ondie_q      <= '0;
      end else if (refresh_tick) begin
         remote_one_q <= pack_remote(mark_one, CHAN_REMOTE_ONE,
                                     remote_diode_one_open_i,
                                     remote_diode_one_temp_i);
         remote_two_q <= pack_remote(mark_two, CHAN_REMOTE_TWO,
                                     remote_diode_two_open_i,
                                     remote_diode_two_temp_i);
         ondie_q      <= {mark_ondie,
                          (RES_ALERT_BIT - TEMP_W)'(0),
                          ondie_thermal_sensor_temp_i};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output code registers

   // only the low twelve bits are kept; the upper nibble is dropped
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < CODE_N; i++) begin
            code_q[i] <= CODE_RESET;
         end
      end else if (wr_code) begin
         code_q[code_idx] <= reg_wdata_i[CODE_W-1:0];
      end
   end

   assign analog_output_a_o = code_q[0];
   assign analog_output_b_o = code_q[1];
   assign analog_output_c_o = code_q[2];
   assign analog_output_d_o = code_q[3];

   ////////////////////////////////////////////////////////////////////////
   // sequence and configuration registers

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         seq_q <= SEQ_RESET;
      end else if (wr_seq) begin
         seq_q <= reg_wdata_i[STAT_W-1:0] & SEQ_MASK;
      end
   end

   assign autocycle_select_o = seq_q;

   // the clearing write is stored too, leaving the alarm pin enabled
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_q <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg_q <= reg_wdata_i;
      end
   end

   assign config_o = cfg_q;

   ////////////////////////////////////////////////////////////////////////
   // read path

   // the word is laid out so the serial side sends [15:8] then [7:0];
   // unmapped addresses, including the result at 0x01, read zero
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_q <= '0;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            ADDR_REMOTE_ONE: rdata_q <= remote_one_q;
            ADDR_REMOTE_TWO: rdata_q <= remote_two_q;
            ADDR_ONDIE:      rdata_q <= ondie_q;
            ADDR_STAT_FIRST: rdata_q <= low_byte(stat_q[0]);
            ADDR_STAT_FIRST + 8'h01:
                             rdata_q <= low_byte(stat_q[1]);
            ADDR_STAT_LAST:  rdata_q <= low_byte(stat_q[2]);
            ADDR_SEQUENCE:   rdata_q <= low_byte(seq_q);
            ADDR_CONFIG:     rdata_q <= cfg_q;
            default:         rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end

   assign reg_rdata_o = rdata_q;

endmodule // mrar_regs

// ===== rtl/mrar_pkg.sv
// constants and types shared by the monitor result and alert register bank
package mrar_pkg;

   // clock and refresh timing
   localparam int unsigned CLK_FREQ_MHZ    = 100;
   localparam int unsigned REFRESH_TIME_US = 5000;
   localparam int unsigned REFRESH_CYCLES  = REFRESH_TIME_US * CLK_FREQ_MHZ;

   // widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int CODE_W = 12;
   localparam int TEMP_W = 11;
   localparam int STAT_W = 8;
   localparam int CHAN_W = 3;
   localparam int STAT_N = 3;

   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_CODE_A     = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_CODE_D     = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_REMOTE_ONE = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_REMOTE_TWO = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_ONDIE      = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_STAT_FIRST = 8'h05;
   localparam logic [ADDR_W-1:0] ADDR_STAT_LAST  = 8'h07;
   localparam logic [ADDR_W-1:0] ADDR_SEQUENCE   = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_CONFIG     = 8'h09;

   // result word fields
   localparam int RES_ALERT_BIT = 15;
   localparam int RES_CHAN_LSB  = 12;
   localparam int RES_OPEN_BIT  = 11;
   localparam int BYTE_W        = 8;

   // source channel codes
   localparam logic [CHAN_W-1:0] CHAN_REMOTE_ONE = 3'h6;
   localparam logic [CHAN_W-1:0] CHAN_REMOTE_TWO = 3'h7;

   // alert status layout: implemented bits per register
   localparam logic [STAT_W-1:0] STAT_VOLT_MASK  = 8'hFF;
   localparam logic [STAT_W-1:0] STAT_CURR_MASK  = 8'h3F;
   localparam logic [STAT_W-1:0] STAT_THERM_MASK = 8'hFF;
   localparam logic [STAT_W-1:0] STAT_ALL_ONES   = 8'hFF;
   localparam logic [STAT_W-1:0] STAT_RESET      = 8'h00;
   localparam int                STAT_THERM_IDX  = 2;

   // thermal status bit groups
   localparam logic [STAT_W-1:0] THERM_ONE_MASK   = 8'h03;
   localparam logic [STAT_W-1:0] THERM_TWO_MASK   = 8'h0C;
   localparam int                THERM_OVER_BIT   = 6;

   // sequence and configuration
   localparam logic [STAT_W-1:0] SEQ_MASK      = 8'h3F;
   localparam logic [STAT_W-1:0] SEQ_RESET     = 8'h00;
   localparam logic [DATA_W-1:0] CFG_RESET     = 16'h0000;
   localparam int                CFG_CLR_BIT_A = 1;
   localparam int                CFG_CLR_BIT_B = 2;
   localparam logic [CODE_W-1:0] CODE_RESET    = 12'h000;

   typedef logic [DATA_W-1:0] mrar_word_t;
   typedef logic [STAT_W-1:0] mrar_stat_t;

   // true for an address shared by a result and an output code
   function automatic logic mrar_is_code_addr(input logic [ADDR_W-1:0] a);
      return (a >= ADDR_CODE_A) && (a <= ADDR_CODE_D);
   endfunction

   // true for one of the alert status addresses
   function automatic logic mrar_is_stat_addr(input logic [ADDR_W-1:0] a);
      return (a >= ADDR_STAT_FIRST) && (a <= ADDR_STAT_LAST);
   endfunction

endpackage

// ===== rtl/mrar_stat_if.sv
// carrier between the register bank and one alert status register
`timescale 1ns/1ps
interface mrar_stat_if;
   import mrar_pkg::*;
   mrar_stat_t evt;
   mrar_stat_t clr;
   mrar_stat_t mask;
   mrar_stat_t q;
   modport stat (input evt, input clr, input mask, output q);
   modport bank (output evt, output clr, output mask, input q);
endinterface

// ===== rtl/mrar_alert_stat.sv
// one sticky alert status register with per-bit clear
`timescale 1ns/1ps
module mrar_alert_stat
   import mrar_pkg::*;
(
   input  wire logic   sys_clk_i,
   input  wire logic   rstn_i,
   mrar_stat_if.stat   port
);

   mrar_stat_t stat_q;
   mrar_stat_t stat_d;

   // a new event beats a clear arriving in the same cycle
   always_comb begin
      stat_d = ((stat_q & ~port.clr) | port.evt) & port.mask;
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         stat_q <= STAT_RESET;
      end else begin
         stat_q <= stat_d;
      end
   end

   assign port.q = stat_q;

endmodule // mrar_alert_stat

// ===== dv/mrar_regs_props.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module mrar_regs_props
   import mrar_pkg::*;
#(
   parameter int unsigned REFRESH_CYC = 20
)
(
   input  wire logic              sys_clk_i,
   input  wire logic              rstn_i,
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [DATA_W-1:0] reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   input  wire logic [DATA_W-1:0] reg_rdata_o,
   input  wire logic              refresh_o,
   input  wire logic [CODE_W-1:0] analog_output_a_o,
   input  wire logic [CODE_W-1:0] analog_output_d_o,
   input  wire logic [STAT_W-1:0] autocycle_select_o,
   input  wire logic [DATA_W-1:0] config_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   ////////////////////////////////////////////////////////////////////////
   // cycles since the last refresh pulse; a counter keeps the check cheap
   int unsigned cnt_q;
   logic        seen_q;
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_q  <= 0;
         seen_q <= 1'b0;
      end else if (refresh_o) begin
         cnt_q  <= 0;
         seen_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_rdata_idle_zero: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data not zero outside a read answer");
   a_code_a_load: assert property (
      reg_wr_i && reg_addr_i == 8'h01 |=>
      {4'h0, analog_output_a_o} == ($past(reg_wdata_i) & 16'h0FFF))
      else $error("output code a not loaded from bits 11-0");
   a_code_d_load: assert property (
      reg_wr_i && reg_addr_i == 8'h04 |=>
      {4'h0, analog_output_d_o} == ($past(reg_wdata_i) & 16'h0FFF))
      else $error("output code d not loaded from bits 11-0");
   a_code_a_hold: assert property (
      !(reg_wr_i && reg_addr_i == 8'h01) |=> $stable(analog_output_a_o))
      else $error("output code a changed without a write");
   a_remote_one_chan: assert property (
      reg_rd_i && reg_addr_i == 8'h02 |=> reg_rdata_o[14:12] == 3'h6)
      else $error("remote one channel code wrong");
   a_remote_two_chan: assert property (
      reg_rd_i && reg_addr_i == 8'h03 |=> reg_rdata_o[14:12] == 3'h7)
      else $error("remote two channel code wrong");
   a_ondie_zero_bits: assert property (
      reg_rd_i && reg_addr_i == 8'h04 |=> reg_rdata_o[14:11] == 4'h0)
      else $error("on-die result bits 14-11 not zero");
   a_seq_write_mask: assert property (
      reg_wr_i && reg_addr_i == 8'h08 |=>
      {8'h00, autocycle_select_o} == ($past(reg_wdata_i) & 16'h003F))
      else $error("sequence register write wrong");
   a_cfg_write_load: assert property (
      reg_wr_i && reg_addr_i == 8'h09 |=> config_o == $past(reg_wdata_i))
      else $error("configuration write not stored");
   a_refresh_period: assert property (
      refresh_o && seen_q |-> cnt_q == REFRESH_CYC - 1)
      else $error("refresh period wrong");
   a_refresh_bound: assert property (cnt_q <= REFRESH_CYC)
      else $error("refresh overdue");
   c_refresh: cover property (refresh_o);
   c_cfg_clear: cover property (
      reg_wr_i && reg_addr_i == 8'h09 && reg_wdata_i[2:1] == 2'b11);
   c_code_write: cover property (reg_wr_i && reg_addr_i == 8'h01);
endmodule // mrar_regs_props

bind mrar_regs mrar_regs_props #(.REFRESH_CYC(REFRESH_CYC)) u_mrar_regs_props (
   .sys_clk_i          (sys_clk_i),
   .rstn_i             (rstn_i),
   .reg_addr_i         (reg_addr_i),
   .reg_wdata_i        (reg_wdata_i),
   .reg_wr_i           (reg_wr_i),
   .reg_rd_i           (reg_rd_i),
   .reg_rdata_o        (reg_rdata_o),
   .refresh_o          (refresh_o),
   .analog_output_a_o  (analog_output_a_o),
   .analog_output_d_o  (analog_output_d_o),
   .autocycle_select_o (autocycle_select_o),
   .config_o           (config_o)
);

// ===== dv/mrar_host_model.sv
// host model: moves whole words over the register port, high byte first
`timescale 1ns/1ps
module mrar_host_model
   import mrar_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic [DATA_W-1:0] reg_rdata_i,
   output logic      [ADDR_W-1:0] reg_addr_o,
   output logic      [DATA_W-1:0] reg_wdata_o,
   output logic                   reg_wr_o,
   output logic                   reg_rd_o
);
   initial begin
      reg_addr_o  = 8'h00;
      reg_wdata_o = 16'h0000;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
   end
   // first byte is the don't-care nibble plus code bits 11-8
   task automatic write_word(input logic [7:0] a, input logic [7:0] hi,
                             input logic [7:0] lo);
      @(posedge sys_clk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= {hi, lo};
      reg_wr_o    <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_o    <= 1'b0;
      // idle data flipped so a stale word never looks valid
      reg_wdata_o <= ~{hi, lo};
      #1;
   endtask
   // answer stands only in the cycle after the read strobe
   task automatic read_word(input logic [7:0] a, output logic [7:0] hi,
                            output logic [7:0] lo);
      @(posedge sys_clk_i);
      reg_addr_o <= a;
      reg_rd_o   <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_o   <= 1'b0;
      #1;
      hi = reg_rdata_i[15:8];
      lo = reg_rdata_i[7:0];
   endtask
endmodule // mrar_host_model

// ===== dv/mrar_regs_test.sv
// self-checking testbench for the register bank
`timescale 1ns/1ps
module mrar_regs_test;
   import mrar_pkg::*;
   logic        sys_clk, rstn, refresh, open_one, open_two;
   logic [7:0]  addr, sel, volt_evt, curr_evt, therm_evt;
   logic [15:0] wdata, rdata, cfg;
   logic        wr, rd_s;
   logic [10:0] t_one, t_two, t_die;
   logic [11:0] outs [4];
   logic [11:0] codes [4] = '{12'hABC, 12'h123, 12'h800, 12'hFFF};
   int          n_errors = 0;
   int          n_tests = 0;
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   mrar_regs #(.REFRESH_CYC(20)) u_mrar_regs (
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd_s), .reg_rdata_o(rdata), .sys_clk_i(sys_clk),
      .rstn_i(rstn), .remote_diode_one_temp_i(t_one),
      .remote_diode_two_temp_i(t_two), .ondie_thermal_sensor_temp_i(t_die),
      .remote_diode_one_open_i(open_one), .remote_diode_two_open_i(open_two),
      .voltage_evt_i(volt_evt), .current_evt_i(curr_evt),
      .thermal_evt_i(therm_evt), .refresh_o(refresh),
      .analog_output_a_o(outs[0]), .analog_output_b_o(outs[1]),
      .analog_output_c_o(outs[2]), .analog_output_d_o(outs[3]),
      .autocycle_select_o(sel), .config_o(cfg));
   mrar_host_model u_mrar_host_model (
      .sys_clk_i(sys_clk), .reg_rdata_i(rdata), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd_s));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      logic [7:0] hi, lo;
      u_mrar_host_model.read_word(a, hi, lo);
      check($sformatf("read %h", a), {hi, lo}, exp);
   endtask
   task automatic wr_w(input logic [7:0] a, input logic [15:0] w);
      u_mrar_host_model.write_word(a, w[15:8], w[7:0]);
   endtask
   task automatic conclude;
      if (n_errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // waits for two pulses so a result taken mid-change is skipped
   task automatic wait_refresh;
      int i;
      for (int k = 0; k < 2; k++) begin
         i = 0;
         do begin
            @(posedge sys_clk);
            #1;
            i++;
         end while (refresh !== 1'b1 && i < 100);
         if (refresh !== 1'b1) begin
            n_errors++;
            conclude();
         end
      end
   endtask
   task automatic pulse(input logic [7:0] v, input logic [7:0] c,
                        input logic [7:0] t);
      @(posedge sys_clk);
      volt_evt  <= v;
      curr_evt  <= c;
      therm_evt <= t;
      @(posedge sys_clk);
      volt_evt  <= 8'h00;
      curr_evt  <= 8'h00;
      therm_evt <= 8'h00;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      t_one = 11'h7FF;
      t_two = 11'h400;
      t_die = 11'h064;
      open_one = 1'b1;
      open_two = 1'b0;
      volt_evt = 8'h00;
      curr_evt = 8'h00;
      therm_evt = 8'h00;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(8'h09, 16'h0000);
      rd(8'h08, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wr_w(8'(i + 1), {4'hF, codes[i]});
         check("output code", {4'h0, outs[i]}, {4'h0, codes[i]});
      end
      rd(8'h01, 16'h0000);
      wait_refresh();
      rd(8'h02, 16'hEFFF);
      rd(8'h03, 16'h7400);
      rd(8'h04, 16'h0064);
      t_one <= 11'h001;
      wait_refresh();
      rd(8'h02, 16'hE801);
      pulse(8'hA5, 8'hFF, 8'hC1);
      rd(8'h05, 16'h00A5);
      rd(8'h06, 16'h003F);
      rd(8'h07, 16'h00C1);
      // markers reach the result words only at the next refresh
      wait_refresh();
      rd(8'h03, 16'hF400);
      rd(8'h04, 16'h8064);
      wr_w(8'h05, 16'h0001);
      rd(8'h05, 16'h00A4);
      wr_w(8'h07, 16'h00FF);
      rd(8'h07, 16'h0000);
      wait_refresh();
      rd(8'h03, 16'h7400);
      wr_w(8'h09, 16'h0006);
      rd(8'h05, 16'h0000);
      rd(8'h06, 16'h0000);
      rd(8'h09, 16'h0006);
      check("config out", cfg, 16'h0006);
      wr_w(8'h08, 16'hFFFF);
      rd(8'h08, 16'h003F);
      check("sequence out", {8'h00, sel}, 16'h003F);
      rd(8'h0A, 16'h0000);
      conclude();
   end
endmodule // mrar_regs_test
